/* design/pwdk_consts.vh */
`ifndef PWDK_CONSTS_VH
`define PWDK_CONSTS_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PWDK_ADR_CTRL    8'h00
`define PWDK_ADR_PERIOD  8'h04
`define PWDK_ADR_CMP1    8'h08
`define PWDK_ADR_CMP2    8'h0c
`define PWDK_ADR_DEAD    8'h10
`define PWDK_ADR_STATUS  8'h14
`define PWDK_ADR_MASK    8'h18
`define PWDK_ADR_CAPT    8'h1c
`define PWDK_ADR_COUNT   8'h20
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define PWDK_C_SWEN      0
`define PWDK_C_RES16     1
`define PWDK_C_MODE_LO   2
`define PWDK_C_MODE_HI   4
`define PWDK_C_TRIG      5
`define PWDK_C_KILL_LO   6
`define PWDK_C_KILL_HI   7
`define PWDK_C_DEAD      8
`define PWDK_C_CAP_LO    9
`define PWDK_C_CAP_HI    10
`define PWDK_C_KCLR      11
// ----------------------------------------------------------------
// modes
// ----------------------------------------------------------------
`define PWDK_M_LEFT      3'h0
`define PWDK_M_RIGHT     3'h1
`define PWDK_M_CENTER    3'h2
`define PWDK_M_DUAL      3'h3
`define PWDK_M_HWSEL     3'h4
`define PWDK_M_DRES      3'h5
`define PWDK_M_DSEL      3'h6
`define PWDK_K_OFF       2'h0
`define PWDK_K_LEVEL     2'h1
`define PWDK_K_PERIOD    2'h2
`define PWDK_K_STICKY    2'h3
`define PWDK_P_NONE      2'h0
`define PWDK_P_RISE      2'h1
`define PWDK_P_FALL      2'h2
`define PWDK_P_BOTH      2'h3
// ----------------------------------------------------------------
// status bits and reset values
// ----------------------------------------------------------------
`define PWDK_S_TERM      0
`define PWDK_S_CMP       1
`define PWDK_S_NEMPTY    2
`define PWDK_S_FULL      3
`define PWDK_S_KILL      4
`define PWDK_S_RUN       5
`define PWDK_RST_CTRL    11'h000
`define PWDK_RST_PERIOD  16'hffff
`define PWDK_RST_CMP     18'h00000
`define PWDK_RST_DEAD    8'h00
`define PWDK_RST_MASK    2'h0
`endif

/* design/pwdk_pwm.v */
// How it works
// - period counter is 8 or 16 bits
// - counter steps once per clock edge
// - reset input reloads period like terminal count
// - reset input forces modulated outputs low
// - run needs hardware and software enable, plus trigger when trigger bit set
// - hardware enable sampled, one cycle latency
// - hardware trigger starts counting when trigger bit set
// - kill forces modulated outputs and phases low
// - hard macro kill: phases or all three modulated outputs
// - kill never touches counter or terminal pulse
// - select input picks first or second compare
// - qualified capture pushes count into fifo
// - two edge-aligned or one center/dual output
// - compare values double buffered at reload
// - dead band gives complementary gapped phases
// - four kill modes, all but off drop phases
// - dither adds two fractional compare bits
// - per-period select of compare output
// - interrupt from terminal count or compare rise
// - terminal pulse registered when counter zero
// - trigger registered, start one clock later
// - interrupt held until status read or mask cleared
`timescale 1ns/1ps
`include "pwdk_consts.vh"
module pwdk_pwm #(
  parameter HARD_MACRO = 0,
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW    = 2
) (
  input  wire        CLK,
  input  wire        RST_N,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [7:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  input  wire        TRIGGER,
  input  wire        RESET_IN,
  input  wire        ENABLE,
  input  wire        KILL,
  input  wire        CMP_SEL,
  input  wire        CAPTURE,
  output reg         MOD_OUT,
  output reg         FIRST_MODULATED_OUTPUT,
  output reg         SECOND_MODULATED_OUTPUT,
  output reg         DEAD_TIME_PHASE_A,
  output reg         DEAD_TIME_PHASE_B,
  output reg         TERMINAL_COUNT_PULSE,
  output reg         IRQ
);
  localparam [FIFO_AW:0] FULL_CNT = FIFO_DEPTH[FIFO_AW:0];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte-lane merge of a write
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  // clip a value to the selected resolution
  function [15:0] rmask;
    input [15:0] v;
    input        r16;
    begin
      rmask = r16 ? v : {8'h00, v[7:0]};
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [10:0] ctrl_reg;
  reg [15:0] period_reg;
  reg [17:0] cmp1_sh_reg;
  reg [17:0] cmp2_sh_reg;
  reg [17:0] cmp1_reg;
  reg [17:0] cmp2_reg;
  reg [15:0] per_act_reg;
  reg [7:0]  dead_reg;
  reg [1:0]  mask_reg;
  reg        st_term_reg;
  reg        st_cmp_reg;
  reg [15:0] count_reg;
  reg        rst_q_reg;
  reg        en_q_reg;
  reg        armed_reg;
  reg        kill_q_reg;
  reg        kill_lat_reg;
  reg        cap_q_reg;
  reg        cap_prev_reg;
  reg        sel_q_reg;
  reg        sel_lat_reg;
  reg [1:0]  dith_reg;
  reg        raw1_reg;
  reg [7:0]  dcnt_reg;
  reg [15:0] fifo_mem [0:FIFO_DEPTH-1];
  reg [FIFO_AW-1:0] wp_reg;
  reg [FIFO_AW-1:0] rp_reg;
  reg [FIFO_AW:0]   fcnt_reg;

  wire       sw_en    = ctrl_reg[`PWDK_C_SWEN];
  wire       res16    = ctrl_reg[`PWDK_C_RES16];
  wire [2:0] mode     = ctrl_reg[`PWDK_C_MODE_HI:`PWDK_C_MODE_LO];
  wire       trig_use = ctrl_reg[`PWDK_C_TRIG];
  wire [1:0] kmode    = ctrl_reg[`PWDK_C_KILL_HI:`PWDK_C_KILL_LO];
  wire       dead_en  = ctrl_reg[`PWDK_C_DEAD];
  wire [1:0] cmode    = ctrl_reg[`PWDK_C_CAP_HI:`PWDK_C_CAP_LO];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // ack one cycle after the request; the write lands on the ack edge
  wire req    = WB_CYC_I & WB_STB_I;
  wire commit = req & WB_ACK_O;
  wire wr     = commit & WB_WE_I;
  wire rd     = commit & ~WB_WE_I;
  wire [7:0]  adr = {WB_ADR_I[7:2], 2'b00};
  wire wr_ctrl  = wr & (adr == `PWDK_ADR_CTRL);
  wire rd_stat  = rd & (adr == `PWDK_ADR_STATUS);
  wire rd_capt  = rd & (adr == `PWDK_ADR_CAPT);
  wire [31:0] wmerge_ctrl = merge({21'h0, ctrl_reg}, WB_DAT_I, WB_SEL_I);
  wire [31:0] wmerge_per  = merge({16'h0, period_reg}, WB_DAT_I, WB_SEL_I);
  wire [31:0] wmerge_cmp1 = merge({14'h0, cmp1_sh_reg}, WB_DAT_I, WB_SEL_I);
  wire [31:0] wmerge_cmp2 = merge({14'h0, cmp2_sh_reg}, WB_DAT_I, WB_SEL_I);
  wire kill_clr = wr_ctrl & wmerge_ctrl[`PWDK_C_KCLR];

  // ----------------------------------------------------------------
  // run qualification
  // ----------------------------------------------------------------
  wire run    = sw_en & en_q_reg & (~trig_use | armed_reg);
  wire at_end = (count_reg == 16'h0000);
  wire reload = rst_q_reg | (run & at_end);
  wire kill_on = (kmode == `PWDK_K_LEVEL) ? kill_q_reg :
                 (kmode == `PWDK_K_OFF) ? 1'b0 :
                 (kill_q_reg | kill_lat_reg);

  // ----------------------------------------------------------------
  // compare logic
  // ----------------------------------------------------------------
  wire [15:0] pos = per_act_reg - count_reg;
  wire [15:0] c1  = rmask(cmp1_reg[15:0], res16);
  wire [15:0] c2  = rmask(cmp2_reg[15:0], res16);
  reg raw1_n;
  reg raw2_n;
  reg rawm_n;
  always @* begin
    raw1_n = pos < c1;
    raw2_n = pos < c2;
    rawm_n = 1'b0;
    case (mode)
      `PWDK_M_LEFT: begin
        rawm_n = raw1_n;
      end
      `PWDK_M_RIGHT: begin
        raw1_n = count_reg < c1;
        raw2_n = count_reg < c2;
        rawm_n = raw1_n;
      end
      `PWDK_M_CENTER: begin
        raw1_n = (pos >= c1) & (count_reg >= c1);
        raw2_n = 1'b0;
        rawm_n = raw1_n;
      end
      `PWDK_M_DUAL: begin
        raw1_n = (pos >= c1) & (pos < c2);
        raw2_n = 1'b0;
        rawm_n = raw1_n;
      end
      `PWDK_M_HWSEL: begin
        rawm_n = sel_q_reg ? raw2_n : raw1_n;
      end
      `PWDK_M_DRES: begin
        raw1_n = (pos < c1) | ((pos == c1) & (cmp1_reg[17:16] > dith_reg));
        raw2_n = 1'b0;
        rawm_n = raw1_n;
      end
      `PWDK_M_DSEL: begin
        rawm_n = sel_lat_reg ? raw2_n : raw1_n;
      end
      default: begin
        rawm_n = raw1_n;
      end
    endcase
    if (~run | rst_q_reg) begin
      raw1_n = 1'b0;
      raw2_n = 1'b0;
      rawm_n = 1'b0;
    end
  end

  wire changing = raw1_n ^ raw1_reg;
  wire cmp_rise = raw1_n & ~raw1_reg;
  wire term_ev  = run & at_end & ~rst_q_reg;
  wire st_term_n = term_ev | (st_term_reg & ~rd_stat);
  wire st_cmp_n  = cmp_rise | (st_cmp_reg & ~rd_stat);

  // ----------------------------------------------------------------
  // capture fifo control
  // ----------------------------------------------------------------
  wire cap_rise = cap_q_reg & ~cap_prev_reg;
  wire cap_fall = ~cap_q_reg & cap_prev_reg;
  wire cap_ev = ((cmode == `PWDK_P_RISE) & cap_rise) |
                ((cmode == `PWDK_P_FALL) & cap_fall) |
                ((cmode == `PWDK_P_BOTH) & (cap_rise | cap_fall));
  wire push = cap_ev & (fcnt_reg != FULL_CNT);
  wire pop  = rd_capt & (fcnt_reg != {(FIFO_AW+1){1'b0}});

  // ----------------------------------------------------------------
  // input sampling
  // ----------------------------------------------------------------
  // pins are synchronous, one register stage each
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_q_reg    <= 1'b0;
      en_q_reg     <= 1'b0;
      kill_q_reg   <= 1'b0;
      cap_q_reg    <= 1'b0;
      cap_prev_reg <= 1'b0;
      sel_q_reg    <= 1'b0;
      armed_reg    <= 1'b0;
      kill_lat_reg <= 1'b0;
    end else begin
      rst_q_reg    <= RESET_IN;
      en_q_reg     <= ENABLE;
      kill_q_reg   <= KILL;
      cap_q_reg    <= CAPTURE;
      cap_prev_reg <= cap_q_reg;
      sel_q_reg    <= CMP_SEL;
      armed_reg    <= sw_en & (armed_reg | TRIGGER);
      // latched kill: set wins over either clear
      if (kill_q_reg & kmode[1])
        kill_lat_reg <= 1'b1;
      else if (~kmode[1] | kill_clr | ((kmode == `PWDK_K_PERIOD) & at_end))
        kill_lat_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // period counter
  // ----------------------------------------------------------------
  // actives reload from shadows only at period boundary, on reset input, or when idle
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      count_reg   <= `PWDK_RST_PERIOD;
      per_act_reg <= `PWDK_RST_PERIOD;
      cmp1_reg    <= `PWDK_RST_CMP;
      cmp2_reg    <= `PWDK_RST_CMP;
      dith_reg    <= 2'h0;
      sel_lat_reg <= 1'b0;
    end else begin
      if (reload | ~run) begin
        per_act_reg <= rmask(period_reg, res16);
        cmp1_reg    <= cmp1_sh_reg;
        cmp2_reg    <= cmp2_sh_reg;
      end
      if (reload) begin
        count_reg   <= rmask(period_reg, res16);
        dith_reg    <= dith_reg + 2'h1;
        sel_lat_reg <= sel_q_reg;
      end else if (run) begin
        count_reg <= count_reg - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  // compare, dead band and kill gating, all outputs registered
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      raw1_reg <= 1'b0;
      dcnt_reg <= 8'h00;
      MOD_OUT  <= 1'b0;
      FIRST_MODULATED_OUTPUT  <= 1'b0;
      SECOND_MODULATED_OUTPUT <= 1'b0;
      DEAD_TIME_PHASE_A <= 1'b0;
      DEAD_TIME_PHASE_B <= 1'b0;
      TERMINAL_COUNT_PULSE <= 1'b0;
    end else begin
      raw1_reg <= raw1_n;
      if (changing)
        dcnt_reg <= dead_reg;
      else if (dcnt_reg != 8'h00)
        dcnt_reg <= dcnt_reg - 8'h01;
      TERMINAL_COUNT_PULSE <= at_end;
      if (kill_on & ((HARD_MACRO == 0) | ~dead_en)) begin
        MOD_OUT <= 1'b0;
        FIRST_MODULATED_OUTPUT  <= 1'b0;
        SECOND_MODULATED_OUTPUT <= 1'b0;
      end else begin
        MOD_OUT <= rawm_n;
        FIRST_MODULATED_OUTPUT  <= raw1_n;
        SECOND_MODULATED_OUTPUT <= raw2_n;
      end
      DEAD_TIME_PHASE_A <= dead_en & ~kill_on & run & ~rst_q_reg &
                           raw1_reg & ~changing & (dcnt_reg == 8'h00);
      DEAD_TIME_PHASE_B <= dead_en & ~kill_on & run & ~rst_q_reg &
                           ~raw1_reg & ~changing & (dcnt_reg == 8'h00);
    end
  end

  // ----------------------------------------------------------------
  // capture fifo
  // ----------------------------------------------------------------
  // full fifo drops new captures
  always @(posedge CLK) begin
    if (push)
      fifo_mem[wp_reg] <= count_reg;
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wp_reg   <= {FIFO_AW{1'b0}};
      rp_reg   <= {FIFO_AW{1'b0}};
      fcnt_reg <= {(FIFO_AW+1){1'b0}};
    end else begin
      if (push)
        wp_reg <= wp_reg + {{(FIFO_AW-1){1'b0}}, 1'b1};
      if (pop)
        rp_reg <= rp_reg + {{(FIFO_AW-1){1'b0}}, 1'b1};
      if (push & ~pop)
        fcnt_reg <= fcnt_reg + {{FIFO_AW{1'b0}}, 1'b1};
      else if (pop & ~push)
        fcnt_reg <= fcnt_reg - {{FIFO_AW{1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // status and interrupt
  // ----------------------------------------------------------------
  // new events win over the read clear
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_term_reg <= 1'b0;
      st_cmp_reg  <= 1'b0;
      IRQ         <= 1'b0;
    end else begin
      st_term_reg <= st_term_n;
      st_cmp_reg  <= st_cmp_n;
      IRQ <= |({st_cmp_n, st_term_n} & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg    <= `PWDK_RST_CTRL;
      period_reg  <= `PWDK_RST_PERIOD;
      cmp1_sh_reg <= `PWDK_RST_CMP;
      cmp2_sh_reg <= `PWDK_RST_CMP;
      dead_reg    <= `PWDK_RST_DEAD;
      mask_reg    <= `PWDK_RST_MASK;
    end else if (wr) begin
      case (adr)
        `PWDK_ADR_CTRL:   ctrl_reg <= wmerge_ctrl[10:0];
        `PWDK_ADR_PERIOD: period_reg <= wmerge_per[15:0];
        `PWDK_ADR_CMP1:   cmp1_sh_reg <= wmerge_cmp1[17:0];
        `PWDK_ADR_CMP2:   cmp2_sh_reg <= wmerge_cmp2[17:0];
        `PWDK_ADR_DEAD:   dead_reg <= WB_SEL_I[0] ? WB_DAT_I[7:0] : dead_reg;
        `PWDK_ADR_MASK:   mask_reg <= WB_SEL_I[0] ? WB_DAT_I[1:0] : mask_reg;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  // read data latched with ack, unmapped reads zero
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= req & ~WB_ACK_O;
      if (req & ~WB_ACK_O) begin
        case (adr)
          `PWDK_ADR_CTRL:   WB_DAT_O <= {21'h0, ctrl_reg};
          `PWDK_ADR_PERIOD: WB_DAT_O <= {16'h0, period_reg};
          `PWDK_ADR_CMP1:   WB_DAT_O <= {14'h0, cmp1_sh_reg};
          `PWDK_ADR_CMP2:   WB_DAT_O <= {14'h0, cmp2_sh_reg};
          `PWDK_ADR_DEAD:   WB_DAT_O <= {24'h0, dead_reg};
          `PWDK_ADR_STATUS: WB_DAT_O <= {26'h0, run, kill_on,
                                         fcnt_reg == FULL_CNT,
                                         fcnt_reg != {(FIFO_AW+1){1'b0}},
                                         st_cmp_reg, st_term_reg};
          `PWDK_ADR_MASK:   WB_DAT_O <= {30'h0, mask_reg};
          `PWDK_ADR_CAPT:   WB_DAT_O <= {16'h0, fifo_mem[rp_reg]};
          `PWDK_ADR_COUNT:  WB_DAT_O <= {16'h0, count_reg};
          default:          WB_DAT_O <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

/* tb/pwdk_chk.sv */
`timescale 1ns/1ps
`include "pwdk_consts.vh"
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module pwdk_chk (
  input logic        CLK,
  input logic        RST_N,
  input logic        WB_CYC_I,
  input logic        WB_STB_I,
  input logic        WB_WE_I,
  input logic [7:0]  WB_ADR_I,
  input logic [3:0]  WB_SEL_I,
  input logic [31:0] WB_DAT_I,
  input logic        WB_ACK_O,
  input logic        RESET_IN,
  input logic        KILL,
  input logic        MOD_OUT,
  input logic        FIRST_MODULATED_OUTPUT,
  input logic        SECOND_MODULATED_OUTPUT,
  input logic        DEAD_TIME_PHASE_A,
  input logic        DEAD_TIME_PHASE_B,
  input logic        IRQ
);
  logic [1:0] kmode_reg;
  logic [7:0] dead_reg;
  logic [1:0] mask_reg;
  logic [8:0] gap_reg;
  logic       wr_b0;
  logic       rd_stat;
  logic       wr_mask;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // accesses committed at the ack edge
  assign wr_b0   = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O & WB_SEL_I[0];
  assign rd_stat = WB_CYC_I & WB_STB_I & !WB_WE_I & WB_ACK_O & (WB_ADR_I == `PWDK_ADR_STATUS);
  assign wr_mask = wr_b0 & (WB_ADR_I == `PWDK_ADR_MASK);
  // shadows of kill mode, dead time, mask; run length of both phases low
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      kmode_reg <= 2'h0;
      dead_reg  <= `PWDK_RST_DEAD;
      mask_reg  <= `PWDK_RST_MASK;
      gap_reg   <= 9'h1ff;
    end else begin
      if (wr_b0 && WB_ADR_I == `PWDK_ADR_CTRL) kmode_reg <= WB_DAT_I[7:6];
      if (wr_b0 && WB_ADR_I == `PWDK_ADR_DEAD) dead_reg <= WB_DAT_I[7:0];
      if (wr_mask) mask_reg <= WB_DAT_I[1:0];
      if (DEAD_TIME_PHASE_A | DEAD_TIME_PHASE_B) gap_reg <= 9'h000;
      else if (gap_reg != 9'h1ff) gap_reg <= gap_reg + 9'h001;
    end
  end
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_kill;
    (KILL && kmode_reg != 2'h0) [*3];
  endsequence
  sequence s_quiet;
    !MOD_OUT && !FIRST_MODULATED_OUTPUT && !SECOND_MODULATED_OUTPUT;
  endsequence
  AST_ACK_NEXT: assert property (s_req |=> WB_ACK_O)
    else $error("bus request not answered after one cycle");
  AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  AST_RESET_IN: assert property (RESET_IN |-> ##2 s_quiet)
    else $error("outputs active under counter reset");
  AST_KILL: assert property (s_kill |-> s_quiet ##0
                             !(DEAD_TIME_PHASE_A || DEAD_TIME_PHASE_B))
    else $error("outputs active while killed");
  AST_DEAD_EXCL: assert property (!(DEAD_TIME_PHASE_A && DEAD_TIME_PHASE_B))
    else $error("both phases high");
  AST_DEAD_GAP: assert property ($rose(DEAD_TIME_PHASE_A) || $rose(DEAD_TIME_PHASE_B)
                                 |-> gap_reg > {1'b0, dead_reg})
    else $error("dead time too short");
  AST_IRQ_HOLD: assert property (IRQ && !rd_stat && !$past(rd_stat) && !wr_mask
                                 && !$past(wr_mask) |=> IRQ)
    else $error("interrupt dropped without status read");
  AST_IRQ_MASK: assert property (mask_reg == 2'h0 && $past(mask_reg) == 2'h0 |-> !IRQ)
    else $error("interrupt with all sources masked");
endmodule

bind pwdk_pwm pwdk_chk u_chk (
  .CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O),
  .RESET_IN(RESET_IN), .KILL(KILL), .MOD_OUT(MOD_OUT), .IRQ(IRQ),
  .FIRST_MODULATED_OUTPUT(FIRST_MODULATED_OUTPUT),
  .SECOND_MODULATED_OUTPUT(SECOND_MODULATED_OUTPUT),
  .DEAD_TIME_PHASE_A(DEAD_TIME_PHASE_A), .DEAD_TIME_PHASE_B(DEAD_TIME_PHASE_B)
);

/* tb/pwdk_hw_model.sv */
`timescale 1ns/1ps
// surrounding logic: control pins change only just after a rising edge
module pwdk_hw_model (
  input  logic clk,
  output logic trigger,
  output logic reset_in,
  output logic enable,
  output logic kill,
  output logic cmp_sel,
  output logic capture
);
  logic [5:0] pins_reg = 6'h00;
  assign {capture, cmp_sel, kill, enable, reset_in, trigger} = pins_reg;
  task automatic put(input logic [5:0] v);
    @(posedge clk);
    pins_reg <= v;
  endtask
endmodule

/* tb/pwdk_pwm_tb.sv */
`timescale 1ns/1ps
`include "pwdk_consts.vh"
module pwdk_pwm_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  wire  [31:0] wb_rd;
  wire         wb_ack, trig, rst_in, en, kill, csel, capt;
  wire         mod_out, pwm_a, pwm_b, ph_a, ph_b, tc, irq;
  wire  [6:0]  outs = {pwm_b, irq, ph_b, ph_a, tc, mod_out, pwm_a};
  logic [5:0]  pv = 6'h00;
  logic [31:0] q, c1, c2;
  int          err_count = 0;
  int          n_checks = 0;
  int          i, k;
  logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h24};
  logic [31:0] rv [8] = '{0, `PWDK_RST_PERIOD, 0, 0, 0, 0, 0, 0};
  // duty table: mode, compare, select, watched output, highs over four periods
  logic [2:0]  md [6] = '{`PWDK_M_LEFT, `PWDK_M_RIGHT, `PWDK_M_HWSEL, `PWDK_M_HWSEL,
                          `PWDK_M_DRES, `PWDK_M_DSEL};
  logic [31:0] cv [6] = '{3, 3, 3, 3, 32'h20003, 3};
  logic        sl [6] = '{0, 0, 0, 1, 0, 1};
  int          sg [6] = '{0, 0, 1, 1, 1, 1};
  logic [31:0] ex [6] = '{12, 12, 12, 24, 14, 24};

  always #12.5 clk = ~clk;

  pwdk_pwm dut (
    .CLK(clk), .RST_N(rst_n), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we),
    .WB_ADR_I(wb_adr), .WB_SEL_I(4'hf), .WB_DAT_I(wb_dat), .WB_DAT_O(wb_rd), .WB_ACK_O(wb_ack),
    .TRIGGER(trig), .RESET_IN(rst_in), .ENABLE(en), .KILL(kill), .CMP_SEL(csel),
    .CAPTURE(capt), .MOD_OUT(mod_out), .FIRST_MODULATED_OUTPUT(pwm_a),
    .SECOND_MODULATED_OUTPUT(pwm_b), .DEAD_TIME_PHASE_A(ph_a), .DEAD_TIME_PHASE_B(ph_b),
    .TERMINAL_COUNT_PULSE(tc), .IRQ(irq)
  );
  pwdk_hw_model hw (
    .clk(clk), .trigger(trig), .reset_in(rst_in), .enable(en), .kill(kill),
    .cmp_sel(csel), .capture(capt)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    @(posedge clk);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {1'b1, 1'b1, w, a, d};
    @(posedge clk);
    for (n = 0; n < 20 && wb_ack !== 1'b1; n++) @(posedge clk);
    if (wb_ack !== 1'b1) err_count++;
    if (wb_ack !== 1'b1) wrap_up;
    r = wb_rd;
    {wb_cyc, wb_stb} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    wb(1'b0, a, 32'h0, r);
  endtask
  task automatic pin(input int b, input logic v);
    pv[b] = v;
    hw.put(pv);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_hi(input int s);
    int n;
    for (n = 0; n < 700 && outs[s] !== 1'b1; n++) @(posedge clk);
    if (outs[s] !== 1'b1) err_count++;
    if (outs[s] !== 1'b1) wrap_up;
  endtask
  task automatic sync;
    @(posedge clk);
    wait_hi(2);
  endtask
  task automatic tc_gap(output logic [31:0] g);
    sync;
    @(posedge clk);
    for (g = 1; g < 700 && tc !== 1'b1; g++) @(posedge clk);
  endtask
  task automatic count_hi(input int s, input int n, output logic [31:0] c);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      c = c + outs[s];
    end
  endtask
  task automatic moves(output logic [31:0] m);
    rd(`PWDK_ADR_COUNT, c1);
    rd(`PWDK_ADR_COUNT, c2);
    m = {31'h0, c1 != c2};
  endtask
  function automatic logic [31:0] cw(input logic [2:0] m, input logic [1:0] kl,
                                     input logic [1:0] cp, input logic db, input logic tg,
                                     input logic r16);
    cw = {20'h0, 1'b0, cp, db, kl, tg, m, r16, 1'b1};
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wr(`PWDK_ADR_STATUS, 32'h3f);
    wr(8'h24, 32'h5a5a5a5a);
    for (i = 0; i < 8; i++) begin
      rd(ra[i], q);
      chk(q, rv[i]);
    end
    $display("test reset values done");
    wr(`PWDK_ADR_PERIOD, 32'h0109);
    wr(`PWDK_ADR_CMP2, 32'h6);
    pin(2, 1'b1);
    wr(`PWDK_ADR_CTRL, cw(`PWDK_M_LEFT, 2'h0, 2'h0, 1'b0, 1'b0, 1'b1));
    pin(1, 1'b1);
    pin(1, 1'b0);
    tc_gap(q);
    chk(q, 32'd266);
    wr(`PWDK_ADR_CTRL, cw(`PWDK_M_LEFT, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0));
    tc_gap(q);
    chk(q, 32'd10);
    $display("test period done");
    pin(2, 1'b0);
    idle(3);
    moves(q);
    chk(q, 0);
    pin(2, 1'b1);
    idle(3);
    moves(q);
    chk(q, 1);
    wr(`PWDK_ADR_CTRL, 32'h0);
    moves(q);
    chk(q, 0);
    wr(`PWDK_ADR_CTRL, cw(`PWDK_M_LEFT, 2'h0, 2'h0, 1'b0, 1'b1, 1'b0));
    moves(q);
    chk(q, 0);
    pin(0, 1'b1);
    pin(0, 1'b0);
    moves(q);
    chk(q, 1);
    $display("test enable and trigger done");
    for (k = 0; k < 2; k++) begin
      wr(`PWDK_ADR_CTRL, cw(`PWDK_M_LEFT, 2'h0, k ? `PWDK_P_NONE : `PWDK_P_RISE, 0, 0, 0));
      pin(1, 1'b1);
      idle(3);
      rd(`PWDK_ADR_COUNT, q);
      chk(q, 32'h9);
      pin(5, 1'b1);
      pin(5, 1'b0);
      idle(3);
      rd(`PWDK_ADR_STATUS, q);
      chk(q[`PWDK_S_NEMPTY], k ? 1'b0 : 1'b1);
      rd(`PWDK_ADR_CAPT, q);
      if (k == 0) chk(q, 32'h9);
      pin(1, 1'b0);
    end
    rd(`PWDK_ADR_STATUS, q);
    chk(q[`PWDK_S_NEMPTY], 1'b0);
    $display("test reset input and capture done");
    for (i = 0; i < 6; i++) begin
      wr(`PWDK_ADR_CMP1, cv[i]);
      wr(`PWDK_ADR_CTRL, cw(md[i], 2'h0, 2'h0, 1'b0, 1'b0, 1'b0));
      pin(4, sl[i]);
      sync;
      sync;
      count_hi(sg[i], 40, q);
      chk(q, ex[i]);
    end
    $display("test output modes done");
    wr(`PWDK_ADR_CTRL, cw(`PWDK_M_LEFT, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0));
    wr(`PWDK_ADR_MASK, 32'h1);
    wait_hi(5);
    chk(irq, 1'b1);
    wr(`PWDK_ADR_MASK, 32'h0);
    idle(2);
    chk(irq, 1'b0);
    wr(`PWDK_ADR_MASK, 32'h2);
    wait_hi(5);
    sync;
    pin(2, 1'b0);
    idle(3);
    chk(irq, 1'b1);
    rd(`PWDK_ADR_STATUS, q);
    chk(q[`PWDK_S_CMP], 1'b1);
    idle(3);
    chk(irq, 1'b0);
    $display("test interrupt done");
    pin(2, 1'b1);
    wr(`PWDK_ADR_DEAD, 32'h1);
    for (k = 0; k < 4; k++) begin
      wr(`PWDK_ADR_CTRL, cw(`PWDK_M_LEFT, k, 2'h0, 1'b1, 1'b0, 1'b0));
      pin(3, 1'b1);
      idle(3);
      count_hi(0, 40, q);
      chk(q, k ? 0 : 12);
      count_hi(6, 40, q);
      chk(q, k ? 0 : 24);
      count_hi(3, 40, q);
      chk(q, k ? 0 : 4);
      count_hi(4, 40, q);
      chk(q, k ? 0 : 20);
      tc_gap(q);
      chk(q, 32'd10);
      pin(3, 1'b0);
      sync;
      sync;
      count_hi(0, 40, q);
      chk(q, (k == 3) ? 0 : 12);
    end
    wr(`PWDK_ADR_CTRL, cw(`PWDK_M_LEFT, 2'h3, 2'h0, 1'b1, 1'b0, 1'b0) | 32'h800);
    sync;
    sync;
    count_hi(0, 40, q);
    chk(q, 12);
    $display("test kill done");
    wrap_up;
  end
endmodule
